// File: hdl/mscg_pkg.sv
/*
  Constants for the module stop clock gate: register offset, field
  positions, reset value and timing figures.
  Assumes a plain byte-wide register port on a single 50 MHz clock.
*/
package mscg_pkg;
  // --------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------
  localparam logic [7:0] STOP_CTRL_OFFSET  = 8'h00;
  localparam logic [7:0] STOP_CTRL_RESET   = 8'hF4;
  // Bits that software may write; bits 3 and 0 read as zero
  localparam logic [7:0] STOP_CTRL_WMASK   = 8'hF6;
  localparam int         SERIAL0_STOP_BIT  = 7;
  localparam int         SERIAL1_STOP_BIT  = 6;
  localparam int         SERIAL2_STOP_BIT  = 5;
  localparam int         SERIAL3_STOP_BIT  = 4;
  localparam int         RESERVED3_BIT     = 3;
  localparam int         CHANNEL_COUNT     = 4;
  // --------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------
  localparam int         CLK_PERIOD_NS     = 20;
endpackage : mscg_pkg

// File: hdl/mscg_gate_cell.sv
/*
  One glitch-free clock gate for a single serial channel.
  Assumes the enable comes from logic on the same clock as clk_i.
*/
`timescale 1ns/10ps
module mscg_gate_cell (
  input  wire logic clk_i,      // Source clock
  input  wire logic rst_i,      // Synchronous reset, active high
  input  wire logic run_i,      // One to let the clock through
  output logic      gclk_o,     // Gated clock
  output logic      running_o   // Latched enable, registered
);
  logic en_low;

  // --------------------------------------------------------------------
  // Enable capture
  // --------------------------------------------------------------------
  // enable on falling edge
  // Changing only while clk is low means no pulse is ever cut short.
  always_ff @(negedge clk_i) begin
    if (rst_i) begin
      en_low <= 1'b0;
    end else begin
      en_low <= run_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      running_o <= 1'b0;
    end else begin
      running_o <= en_low;
    end
  end

  assign gclk_o = clk_i & en_low;
endmodule : mscg_gate_cell

// File: hdl/mscg_top.sv
/*
  Module stop clock gate: one 8-bit stop register and four gated
  clocks for the serial channels.
  Assumes a register master that uses one-cycle strobes, byte data, and
  a separate power-on reset; manual reset and standby are only inputs.
*/
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
module mscg_top (
  input  wire logic       mclk_i,        // 50 MHz clock
  input  wire logic       sys_rst_i,     // Power-on reset, sync, high
  input  wire logic       man_rst_i,     // Manual reset, does not clear
  input  wire logic       standby_i,     // Software standby, no clear
  input  wire logic [7:0] reg_addr_i,    // Register byte address
  input  wire logic [7:0] reg_wdata_i,   // Write data
  input  wire logic       reg_wr_i,      // Write strobe
  input  wire logic       reg_rd_i,      // Read strobe
  output logic      [7:0] reg_rdata_o,   // Read data, one cycle later
  output logic      [3:0] serial_clk_o,  // Gated channel clocks
  output logic      [3:0] serial_run_o   // Channel clock running, reg
);
  logic [7:0] module_clock_stop_ctrl_4;
  logic [3:0] run_req;
  logic [3:0] cell_run;
  logic       hit;
  logic       man_rst_meta;
  logic       man_rst_sync;
  logic       standby_meta;
  logic       standby_sync;

  assign hit = (reg_addr_i == mscg_pkg::STOP_CTRL_OFFSET);

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  // Manual reset and standby arrive from pins; two flops before any use.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      man_rst_meta <= 1'b0;
      man_rst_sync <= 1'b0;
    end else begin
      man_rst_meta <= man_rst_i;
      man_rst_sync <= man_rst_meta;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      standby_meta <= 1'b0;
      standby_sync <= 1'b0;
    end else begin
      standby_meta <= standby_i;
      standby_sync <= standby_meta;
    end
  end

  // --------------------------------------------------------------------
  // Stop register
  // --------------------------------------------------------------------
  // reset value and retention
  // Only the power-on reset clears; manual reset and standby are ignored.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      module_clock_stop_ctrl_4 <= mscg_pkg::STOP_CTRL_RESET;
    end else if (reg_wr_i && hit) begin
      module_clock_stop_ctrl_4 <= reg_wdata_i & mscg_pkg::STOP_CTRL_WMASK;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i && hit) begin
      reg_rdata_o <= module_clock_stop_ctrl_4 & mscg_pkg::STOP_CTRL_WMASK;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // --------------------------------------------------------------------
  // Channel gates
  // --------------------------------------------------------------------
  // stop bits
  // Channel n uses bit 7-n, so stop set means clock halted.
  assign run_req[0] = ~module_clock_stop_ctrl_4[mscg_pkg::SERIAL0_STOP_BIT];
  assign run_req[1] = ~module_clock_stop_ctrl_4[mscg_pkg::SERIAL1_STOP_BIT];
  assign run_req[2] = ~module_clock_stop_ctrl_4[mscg_pkg::SERIAL2_STOP_BIT];
  assign run_req[3] = ~module_clock_stop_ctrl_4[mscg_pkg::SERIAL3_STOP_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < mscg_pkg::CHANNEL_COUNT; gi++) begin : g_cell
      mscg_gate_cell u_cell (
        .clk_i     (mclk_i),
        .rst_i     (sys_rst_i),
        .run_i     (run_req[gi]),
        .gclk_o    (serial_clk_o[gi]),
        .running_o (cell_run[gi])
      );
    end
  endgenerate

  // Gated clocks are combinational by nature; the status is registered.
  assign serial_run_o = cell_run;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  property p_reset_value;
    @(posedge mclk_i) sys_rst_i |=> (module_clock_stop_ctrl_4 == mscg_pkg::STOP_CTRL_RESET);
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("stop reg reset not F4");

  property p_retain;
    @(posedge mclk_i) disable iff (sys_rst_i)
      !(reg_wr_i && hit) |=> $stable(module_clock_stop_ctrl_4);
  endproperty
  a_retain: assert property (p_retain) else $error("stop reg changed without write");

  property p_write;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (reg_wr_i && hit) |=> (module_clock_stop_ctrl_4 == ($past(reg_wdata_i) & mscg_pkg::STOP_CTRL_WMASK));
  endproperty
  a_write: assert property (p_write) else $error("write not stored");

  property p_read;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (reg_rd_i && hit) |=> (reg_rdata_o == $past(module_clock_stop_ctrl_4));
  endproperty
  a_read: assert property (p_read) else $error("read data wrong");

  property p_ch0;
    @(posedge mclk_i) disable iff (sys_rst_i)
      $fell(module_clock_stop_ctrl_4[7]) |-> ##[1:2] serial_run_o[0];
  endproperty
  a_ch0: assert property (p_ch0) else $error("channel 0 did not start");

  property p_ch1;
    @(posedge mclk_i) disable iff (sys_rst_i)
      $rose(module_clock_stop_ctrl_4[6]) |-> ##[1:2] !serial_run_o[1];
  endproperty
  a_ch1: assert property (p_ch1) else $error("channel 1 did not stop");

  property p_ch2;
    @(posedge mclk_i) disable iff (sys_rst_i)
      module_clock_stop_ctrl_4[5] [*3] |-> !serial_run_o[2];
  endproperty
  a_ch2: assert property (p_ch2) else $error("channel 2 runs while stopped");

  property p_ch3;
    @(posedge mclk_i) disable iff (sys_rst_i)
      !module_clock_stop_ctrl_4[4] [*3] |-> serial_run_o[3];
  endproperty
  a_ch3: assert property (p_ch3) else $error("channel 3 halted while run");

  property p_rsvd;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (reg_rdata_o[3] == 1'b0) && (reg_rdata_o[0] == 1'b0);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit read as one");

  // --------------------------------------------------------------------
  // Channel start and stop
  // --------------------------------------------------------------------
  property p_ch0_stop;
    @(posedge mclk_i) disable iff (sys_rst_i)
      $rose(module_clock_stop_ctrl_4[mscg_pkg::SERIAL0_STOP_BIT]) |-> ##[1:2] !serial_run_o[0];
  endproperty
  a_ch0_stop: assert property (p_ch0_stop) else $error("channel 0 did not stop");

  property p_ch1_start;
    @(posedge mclk_i) disable iff (sys_rst_i)
      $fell(module_clock_stop_ctrl_4[mscg_pkg::SERIAL1_STOP_BIT]) |-> ##[1:2] serial_run_o[1];
  endproperty
  a_ch1_start: assert property (p_ch1_start) else $error("channel 1 did not start");

  property p_ch2_start;
    @(posedge mclk_i) disable iff (sys_rst_i)
      $fell(module_clock_stop_ctrl_4[mscg_pkg::SERIAL2_STOP_BIT]) |-> ##[1:2] serial_run_o[2];
  endproperty
  a_ch2_start: assert property (p_ch2_start) else $error("channel 2 did not start");

  property p_ch3_stop;
    @(posedge mclk_i) disable iff (sys_rst_i)
      $rose(module_clock_stop_ctrl_4[mscg_pkg::SERIAL3_STOP_BIT]) |-> ##[1:2] !serial_run_o[3];
  endproperty
  a_ch3_stop: assert property (p_ch3_stop) else $error("channel 3 did not stop");

  property p_ch0_hold_stop;
    @(posedge mclk_i) disable iff (sys_rst_i)
      module_clock_stop_ctrl_4[mscg_pkg::SERIAL0_STOP_BIT] [*3] |-> !serial_run_o[0];
  endproperty
  a_ch0_hold_stop: assert property (p_ch0_hold_stop) else $error("channel 0 runs while stopped");

  property p_ch0_hold_run;
    @(posedge mclk_i) disable iff (sys_rst_i)
      !module_clock_stop_ctrl_4[mscg_pkg::SERIAL0_STOP_BIT] [*3] |-> serial_run_o[0];
  endproperty
  a_ch0_hold_run: assert property (p_ch0_hold_run) else $error("channel 0 halted while run");

  property p_ch1_hold_stop;
    @(posedge mclk_i) disable iff (sys_rst_i)
      module_clock_stop_ctrl_4[mscg_pkg::SERIAL1_STOP_BIT] [*3] |-> !serial_run_o[1];
  endproperty
  a_ch1_hold_stop: assert property (p_ch1_hold_stop) else $error("channel 1 runs while stopped");

  property p_ch1_hold_run;
    @(posedge mclk_i) disable iff (sys_rst_i)
      !module_clock_stop_ctrl_4[mscg_pkg::SERIAL1_STOP_BIT] [*3] |-> serial_run_o[1];
  endproperty
  a_ch1_hold_run: assert property (p_ch1_hold_run) else $error("channel 1 halted while run");

  property p_ch2_hold_run;
    @(posedge mclk_i) disable iff (sys_rst_i)
      !module_clock_stop_ctrl_4[mscg_pkg::SERIAL2_STOP_BIT] [*3] |-> serial_run_o[2];
  endproperty
  a_ch2_hold_run: assert property (p_ch2_hold_run) else $error("channel 2 halted while run");

  property p_ch3_hold_stop;
    @(posedge mclk_i) disable iff (sys_rst_i)
      module_clock_stop_ctrl_4[mscg_pkg::SERIAL3_STOP_BIT] [*3] |-> !serial_run_o[3];
  endproperty
  a_ch3_hold_stop: assert property (p_ch3_hold_stop) else $error("channel 3 runs while stopped");

  // --------------------------------------------------------------------
  // Gated clock against status
  // --------------------------------------------------------------------
  // Sampled on the falling edge, where an open gate shows its high phase.
  property p_gate0;
    @(negedge mclk_i) disable iff (sys_rst_i)
      serial_clk_o[0] == serial_run_o[0];
  endproperty
  a_gate0: assert property (p_gate0) else $error("channel 0 clock and status differ");

  property p_gate1;
    @(negedge mclk_i) disable iff (sys_rst_i)
      serial_clk_o[1] == serial_run_o[1];
  endproperty
  a_gate1: assert property (p_gate1) else $error("channel 1 clock and status differ");

  property p_gate2;
    @(negedge mclk_i) disable iff (sys_rst_i)
      serial_clk_o[2] == serial_run_o[2];
  endproperty
  a_gate2: assert property (p_gate2) else $error("channel 2 clock and status differ");

  property p_gate3;
    @(negedge mclk_i) disable iff (sys_rst_i)
      serial_clk_o[3] == serial_run_o[3];
  endproperty
  a_gate3: assert property (p_gate3) else $error("channel 3 clock and status differ");

  // --------------------------------------------------------------------
  // Register port checks
  // --------------------------------------------------------------------
  property p_hold_pins;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (man_rst_sync || standby_sync) && !(reg_wr_i && hit) |=> $stable(module_clock_stop_ctrl_4);
  endproperty
  a_hold_pins: assert property (p_hold_pins) else $error("stop reg changed in manual reset or standby");

  property p_wr_other;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (reg_wr_i && !hit) |=> $stable(module_clock_stop_ctrl_4);
  endproperty
  a_wr_other: assert property (p_wr_other) else $error("write to other address changed stop reg");

  property p_wr_rd;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (reg_wr_i && hit) ##1 (reg_rd_i && hit) |=>
        (reg_rdata_o == ($past(reg_wdata_i, 2) & mscg_pkg::STOP_CTRL_WMASK));
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("back to back read missed write");

  property p_rd_idle;
    @(posedge mclk_i) disable iff (sys_rst_i)
      !(reg_rd_i && hit) |=> (reg_rdata_o == 8'h00);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");

  property p_rd_other;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (reg_rd_i && !hit) |=> (reg_rdata_o == 8'h00);
  endproperty
  a_rd_other: assert property (p_rd_other) else $error("other address read not zero");

  property p_reg_rsvd;
    @(posedge mclk_i) disable iff (sys_rst_i)
      module_clock_stop_ctrl_4[mscg_pkg::RESERVED3_BIT] == 1'b0;
  endproperty
  a_reg_rsvd: assert property (p_reg_rsvd) else $error("reserved bit stored as one");

  property p_reset_run;
    @(posedge mclk_i)
      sys_rst_i |=> (serial_run_o == 4'h0);
  endproperty
  a_reset_run: assert property (p_reset_run) else $error("channel runs after reset");

  c_write: cover property (@(posedge mclk_i) disable iff (sys_rst_i) reg_wr_i && hit);
  c_read: cover property (@(posedge mclk_i) disable iff (sys_rst_i) reg_rd_i && hit);
  c_all_run: cover property (@(posedge mclk_i) disable iff (sys_rst_i) serial_run_o == 4'hF);
  c_mrst: cover property (@(posedge mclk_i) disable iff (sys_rst_i) man_rst_sync || standby_sync);
endmodule : mscg_top

// File: verification/mscg_serial_sink.sv
/*
  Model of the four serial channel clock inputs; counts whole pulses.
  Assumes a 20 ns source clock, so a whole high phase lasts 10 ns.
*/
`timescale 1ns/10ps
module mscg_serial_sink (
  input  wire logic [3:0] serial_clk_i,  // Gated channel clocks
  output int              pulses_o [4],  // Whole pulses per channel
  output int              short_o        // Truncated pulses seen
);
  realtime rise_t [4];
  int      whole  [4] = '{default: 0};
  int      cut    [4] = '{default: 0};
  // One writer per counter; ports only mirror them
  assign pulses_o = whole;
  assign short_o  = cut[0] + cut[1] + cut[2] + cut[3];
  for (genvar n = 0; n < 4; n++) begin : g_ch
    always @(posedge serial_clk_i[n]) rise_t[n] = $realtime;
    always @(negedge serial_clk_i[n]) begin
      if ($realtime - rise_t[n] < 9.9) cut[n]++;
      else whole[n]++;
    end
  end
endmodule : mscg_serial_sink

// File: verification/mscg_top_tb.sv
/*
  Self-checking bench for the module stop clock gate.
  Assumes the stop register at offset zero and read data one cycle late.
*/
`timescale 1ns/10ps
module mscg_top_tb;
  logic       mclk_i = 0, sys_rst_i = 1, man_rst_i = 0, standby_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, rd_v;
  logic [3:0] serial_clk_o, serial_run_o;
  int         pulses [4], base [4];
  int         short_cnt, errors = 0, tests_run = 0;

  initial forever #10 mclk_i = ~mclk_i;
  mscg_top DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .man_rst_i(man_rst_i), .standby_i(standby_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .serial_clk_o(serial_clk_o), .serial_run_o(serial_run_o));
  mscg_serial_sink sink (.serial_clk_i(serial_clk_o), .pulses_o(pulses), .short_o(short_cnt));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'h1;
    @(posedge mclk_i);
    reg_wr_i <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'h1;
    @(posedge mclk_i);
    reg_rd_i <= 1'h0;
    #1 rd_v = reg_rdata_o;
  endtask : rd
  // Ten-cycle window: running channels give ten whole pulses, others none
  task automatic window(input logic [3:0] run);
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
    chk(16'(serial_run_o), 16'(run));
    // Pulse counts move on falling edges only, so rising edges are quiet
    @(posedge mclk_i);
    base = pulses;
    repeat (10) @(posedge mclk_i);
    for (int n = 0; n < 4; n++) chk(16'(pulses[n] - base[n]), run[n] ? 16'h000A : 16'h0000);
  endtask : window
  task automatic t_reset;
    rd(8'h00);
    chk(16'(rd_v), 16'h00F4);
    window(4'h0);
  endtask : t_reset
  task automatic t_channels;
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 8'hF0 & ~(8'h80 >> i));
      window(4'h1 << i);
    end
    wr(8'h00, 8'h00);
    window(4'hF);
    wr(8'h00, 8'hF0);
    window(4'h0);
    chk(16'(short_cnt), 16'h0000);
  endtask : t_channels
  task automatic t_reserved;
    wr(8'h00, 8'hFF);
    rd(8'h00);
    chk(16'(rd_v), 16'h00F6);
    wr(8'h01, 8'h00);
    rd(8'h01);
    chk(16'(rd_v), 16'h0000);
    rd(8'h00);
    chk(16'(rd_v), 16'h00F6);
  endtask : t_reserved
  task automatic t_retain;
    wr(8'h00, 8'h56);
    man_rst_i <= 1'h1;
    standby_i <= 1'h1;
    repeat (6) @(posedge mclk_i);
    man_rst_i <= 1'h0;
    standby_i <= 1'h0;
    rd(8'h00);
    chk(16'(rd_v), 16'h0056);
    window(4'h5);
    @(posedge mclk_i);
    sys_rst_i <= 1'h1;
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'h0;
    rd(8'h00);
    chk(16'(rd_v), 16'h00F4);
  endtask : t_retain
  task automatic conclude;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  initial begin
    repeat (8) @(posedge mclk_i);
    sys_rst_i <= 1'h0;
    t_reset;
    t_channels;
    t_reserved;
    t_retain;
    conclude;
  end
  // Hang guard, far beyond the whole run
  initial begin
    #1000000;
    errors++;
    conclude;
  end
endmodule : mscg_top_tb
